//--- rtl/srst_pkg.sv
// package for the smart reset controller: timing constants and carriers
package srst_pkg;
   // ---------------------------------------------------------------
   // clock and timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS      = 100;
   localparam int PIN_FILTER_NS      = 2000;   // reset pin input filter
   localparam int IO_UV_FILTER_NS    = 3000;   // least io filter, 3 us
   localparam int UV_FILTER_NS       = 10000;  // main supply uv filter
   localparam int UV_RELEASE_US      = 10000;  // uv release delay
   localparam int HOLD_TIME_US       = 20000;  // long undervoltage hold
   localparam int NOLATCH_PULSE_US   = 1000;   // no-latch pulse time
   localparam int OV_FIRST_US        = 1000;   // first overvoltage limit
   localparam int OV_SECOND_US       = 10000;  // second overvoltage limit
   localparam int PIN_FILTER_CYC  = (PIN_FILTER_NS + CLK_PERIOD_NS - 1)
                                    / CLK_PERIOD_NS;
   localparam int IO_UV_CYC       = (IO_UV_FILTER_NS + CLK_PERIOD_NS - 1)
                                    / CLK_PERIOD_NS;
   localparam int UV_FILTER_CYC   = (UV_FILTER_NS + CLK_PERIOD_NS - 1)
                                    / CLK_PERIOD_NS;
   localparam int UV_RELEASE_CYC  = UV_RELEASE_US * 1000 / CLK_PERIOD_NS;
   localparam int HOLD_CYC        = HOLD_TIME_US * 1000 / CLK_PERIOD_NS;
   localparam int NOLATCH_CYC     = NOLATCH_PULSE_US * 1000 / CLK_PERIOD_NS;
   localparam int OV_FIRST_CYC    = OV_FIRST_US * 1000 / CLK_PERIOD_NS;
   localparam int OV_SECOND_CYC   = OV_SECOND_US * 1000 / CLK_PERIOD_NS;
   localparam int CNT_W           = 24;
   localparam int UV_DISABLE_BIT  = 3;       // bit in configuration reg six
   // ---------------------------------------------------------------
   // carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      logic crank_undervoltage_flag;
      logic long_undervoltage_reset_flag;
      logic nolatch_pulse_flag;
      logic battery_overvoltage_flag;
   } srst_flags_t;
   typedef struct packed {
      logic logic_reset;      // main internal logic under reset
      logic lb_reset;         // low-battery driver logic under reset
      logic drivers_off;      // all drivers off, configuration kept
      logic supplies_off;     // relay driver and regulators off
      logic output_disable_bit;
   } srst_ctrl_t;
   typedef enum logic [2:0] {
      SRST_IDLE    = 3'b001,
      SRST_ACTIVE  = 3'b010,
      SRST_RELEASE = 3'b100
   } srst_state_t;
endpackage : srst_pkg

//--- rtl/srst_controller.sv
// smart reset controller: combines reset sources and drives the reset pin
`timescale 1ns/1ns
`default_nettype none
module srst_controller
   import srst_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        resetn,
   // supply and event monitors
   input  wire logic        main_logic_supply_low,
   input  wire logic        main_logic_supply_high,
   input  wire logic        io_supply_low,
   input  wire logic        battery_overvoltage,
   input  wire logic        power_down,
   input  wire logic        key_on,
   input  wire logic        watchdog_reset_source,
   input  wire logic        watchdog_alarm,
   // host settings
   input  wire logic [7:0]  configuration_register_six,
   input  wire logic        nolatch_reset_enable,
   input  wire logic        latch_enable_low,
   input  wire logic        latch_timeout,
   input  wire logic        diag_read,
   // reset pin, open drain
   input  wire logic        reset_pin_in,
   output logic             reset_pin_out,
   output logic             reset_pin_oe,
   // alarm pin, open drain
   output logic             watchdog_alarm_output,
   output logic             watchdog_alarm_oe,
   // status and control towards the rest of the device
   output srst_flags_t      flags,
   output srst_ctrl_t       ctrl,
   output logic             system_enable
);
   // ---------------------------------------------------------------
   // filters and timers
   // ---------------------------------------------------------------
   logic [CNT_W-1:0] uv_cnt, next_uv_cnt;
   logic [CNT_W-1:0] io_cnt, next_io_cnt;
   logic [CNT_W-1:0] ov_cnt, next_ov_cnt;
   logic [CNT_W-1:0] ext_cnt, next_ext_cnt;
   logic [CNT_W-1:0] rel_cnt, next_rel_cnt;
   logic [CNT_W-1:0] nl_cnt, next_nl_cnt;
   logic             key_q, next_key_q;
   logic             supply_ok, next_supply_ok;
   logic             uv_long, next_uv_long;
   logic             uv_src, io_src, ov1, ov2, ext_src, key_rise, latch_mode;
   logic             drive_low, any_src;
   srst_state_t      state, next_state;
   srst_flags_t      next_flags;
   srst_ctrl_t       next_ctrl;
   logic             next_pin_oe, next_alarm_oe, next_sys_en;

   // level filters: each counts while its condition holds
   always_comb begin
      next_uv_cnt  = uv_cnt;
      next_io_cnt  = io_cnt;
      next_ov_cnt  = ov_cnt;
      next_ext_cnt = ext_cnt;
      // main uv ignored while disabled by the host
      if (main_logic_supply_low &&
          !configuration_register_six[UV_DISABLE_BIT]) begin
         if (uv_cnt != CNT_W'(HOLD_CYC)) next_uv_cnt = uv_cnt + 1'b1;
      end else begin
         next_uv_cnt = '0;
      end
      if (io_supply_low) begin
         if (io_cnt != CNT_W'(IO_UV_CYC)) next_io_cnt = io_cnt + 1'b1;
      end else begin
         next_io_cnt = '0;
      end
      if (battery_overvoltage) begin
         if (ov_cnt != CNT_W'(OV_SECOND_CYC)) next_ov_cnt = ov_cnt + 1'b1;
      end else begin
         next_ov_cnt = '0;
      end
      // only an outside low counts, not our own pull
      if (!reset_pin_in && !reset_pin_oe) begin
         if (ext_cnt != CNT_W'(PIN_FILTER_CYC))
            next_ext_cnt = ext_cnt + 1'b1;
      end else begin
         next_ext_cnt = '0;
      end
   end

   assign uv_src   = (uv_cnt >= CNT_W'(UV_FILTER_CYC));
   assign io_src   = (io_cnt == CNT_W'(IO_UV_CYC));
   assign ov1      = (ov_cnt >= CNT_W'(OV_FIRST_CYC));
   assign ov2      = (ov_cnt == CNT_W'(OV_SECOND_CYC));
   assign ext_src  = (ext_cnt == CNT_W'(PIN_FILTER_CYC));
   assign latch_mode = !latch_enable_low;
   // key re-rise in latch mode with no-latch reset enabled, latch_timeout not looked at
   assign key_rise = key_on && !key_q && latch_mode && nolatch_reset_enable;
   // combined sources; power down acts without any filter
   assign any_src  = uv_src || io_src || ov2 || power_down ||
                     watchdog_reset_source || !supply_ok;
   assign drive_low = any_src || (nl_cnt != '0) ||
                      (rel_cnt != '0) || key_rise;

   // ---------------------------------------------------------------
   // sequencer, timers and flags
   // ---------------------------------------------------------------
   always_comb begin
      next_state     = state;
      next_rel_cnt   = rel_cnt;
      next_nl_cnt    = nl_cnt;
      next_key_q     = key_on;
      next_supply_ok = supply_ok;
      next_uv_long   = uv_long;
      next_flags     = flags;
      // a read clears, an event in the same cycle wins
      if (diag_read) begin
         next_flags.crank_undervoltage_flag      = 1'b0;
         next_flags.long_undervoltage_reset_flag = 1'b0;
         next_flags.nolatch_pulse_flag           = 1'b0;
         next_flags.battery_overvoltage_flag     = 1'b0;
      end
      // supply missing at first key-on keeps reset low
      if (main_logic_supply_high) next_supply_ok = 1'b1;
      else if (uv_src || power_down) next_supply_ok = 1'b0;
      if (uv_src) next_flags.crank_undervoltage_flag = 1'b1;
      if (uv_cnt == CNT_W'(HOLD_CYC)) begin
         next_uv_long = 1'b1;
         next_flags.long_undervoltage_reset_flag = 1'b1;
      end
      if (ov1) next_flags.battery_overvoltage_flag = 1'b1;
      if (key_rise) begin
         next_nl_cnt = CNT_W'(NOLATCH_CYC);
         next_flags.nolatch_pulse_flag = 1'b1;
      end else if (nl_cnt != '0) begin
         next_nl_cnt = nl_cnt - 1'b1;
      end
      case (state)
         SRST_IDLE: begin
            if (drive_low) next_state = SRST_ACTIVE;
         end
         SRST_ACTIVE: begin
            if (!any_src && nl_cnt == '0 && !key_rise) begin
               next_state   = SRST_RELEASE;
               next_rel_cnt = uv_long ? CNT_W'(UV_RELEASE_CYC)
                                      : CNT_W'(1);
            end
         end
         SRST_RELEASE: begin
            if (any_src || key_rise) begin
               next_state   = SRST_ACTIVE;
               next_rel_cnt = '0;
            end else if (rel_cnt <= CNT_W'(1)) begin
               next_state   = SRST_IDLE;
               next_rel_cnt = '0;
               next_uv_long = 1'b0;
            end else begin
               next_rel_cnt = rel_cnt - 1'b1;
            end
         end
         default: next_state = SRST_IDLE;
      endcase
   end

   // ---------------------------------------------------------------
   // outputs towards pins and internal logic
   // ---------------------------------------------------------------
   always_comb begin
      next_pin_oe   = (next_state != SRST_IDLE);
      next_alarm_oe = watchdog_alarm;
      // short uv spares low-battery logic, long one does not
      next_ctrl.logic_reset  = next_pin_oe || ext_src;
      next_ctrl.lb_reset     = power_down || ov2 || next_uv_long ||
                               (nl_cnt != '0) || key_rise ||
                               (ext_src && ext_cnt == CNT_W'(PIN_FILTER_CYC)
                                && next_uv_long);
      next_ctrl.drivers_off  = ov1 || next_pin_oe || ext_src;
      next_ctrl.supplies_off = power_down;
      next_ctrl.output_disable_bit = next_ctrl.logic_reset ? 1'b1
                                     : ctrl.output_disable_bit;
      if (!next_ctrl.logic_reset && !ov1)
         next_ctrl.output_disable_bit = 1'b0;
      next_sys_en = (latch_mode && !latch_timeout) || key_on;
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         uv_cnt    <= '0;
         io_cnt    <= '0;
         ov_cnt    <= '0;
         ext_cnt   <= '0;
         rel_cnt   <= '0;
         nl_cnt    <= '0;
         key_q     <= 1'b1;   // no false key edge when reset lets go
         supply_ok <= 1'b0;
         uv_long   <= 1'b0;
         state     <= SRST_ACTIVE;
         flags     <= '0;
         ctrl      <= '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
         reset_pin_oe      <= 1'b1;
         watchdog_alarm_oe <= 1'b0;
         system_enable     <= 1'b0;
      end else begin
         uv_cnt    <= next_uv_cnt;
         io_cnt    <= next_io_cnt;
         ov_cnt    <= next_ov_cnt;
         ext_cnt   <= next_ext_cnt;
         rel_cnt   <= next_rel_cnt;
         nl_cnt    <= next_nl_cnt;
         key_q     <= next_key_q;
         supply_ok <= next_supply_ok;
         uv_long   <= next_uv_long;
         state     <= next_state;
         flags     <= next_flags;
         ctrl      <= next_ctrl;
         reset_pin_oe      <= next_pin_oe;
         watchdog_alarm_oe <= next_alarm_oe;
         system_enable     <= next_sys_en;
      end
   end

   // open-drain: data always low, only the enable moves
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         reset_pin_out         <= 1'b0;
         watchdog_alarm_output <= 1'b0;
      end else begin
         reset_pin_out         <= 1'b0;
         watchdog_alarm_output <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   // power down needs no filter, one cycle to the pin
   sequence s_pd; power_down; endsequence
   chk_powerdown_reset: assert property (s_pd |=> reset_pin_oe)
      else $error("power down did not pull reset");
   chk_powerdown_supply: assert property
      (s_pd |=> ctrl.supplies_off)
      else $error("power down left supplies on");
   chk_ov_reset: assert property (ov2 |=> reset_pin_oe)
      else $error("long overvoltage without reset");
   chk_ov_drivers: assert property (ov1 |=> ctrl.drivers_off)
      else $error("overvoltage left drivers on");
   chk_ov_flag: assert property
      (ov1 |=> flags.battery_overvoltage_flag)
      else $error("overvoltage flag not set");
   chk_crank_flag: assert property
      (uv_src |=> flags.crank_undervoltage_flag)
      else $error("crank flag not set");
   // a read only clears when no event sets in the same cycle
   chk_read_clear: assert property (diag_read && !uv_src && !ov1
      && !key_rise && uv_cnt != CNT_W'(HOLD_CYC)
      |=> flags == '0)
      else $error("read did not clear flags");
   chk_uv_disabled: assert property
      (configuration_register_six[UV_DISABLE_BIT] |=> uv_cnt == '0)
      else $error("disabled undervoltage still counted");
   chk_io_reset: assert property (io_src |=> reset_pin_oe)
      else $error("io undervoltage without reset");
   chk_ext_reset: assert property (ext_src |=> ctrl.logic_reset)
      else $error("outside reset not applied");
   chk_supply_absent: assert property (!supply_ok |=> reset_pin_oe)
      else $error("reset released without supply");
   chk_nolatch_pulse: assert property
      (key_rise |=> reset_pin_oe && flags.nolatch_pulse_flag)
      else $error("no-latch pulse missing");
   // long dip escalates: low-battery logic joins the reset
   chk_long_uv: assert property
      (uv_cnt == CNT_W'(HOLD_CYC) |=> uv_long && ctrl.lb_reset
       && flags.long_undervoltage_reset_flag)
      else $error("long undervoltage not escalated");
   // after a long dip the release phase loads the full delay
   sequence s_long_release;
      state == SRST_ACTIVE && next_state == SRST_RELEASE && uv_long;
   endsequence
   chk_release_delay: assert property
      (s_long_release |=> rel_cnt == CNT_W'(UV_RELEASE_CYC))
      else $error("release delay not loaded");
   // judged in the deciding cycle, a new source may follow at once
   chk_release_clean: assert property
      (reset_pin_oe && !next_pin_oe |-> !any_src && nl_cnt == '0)
      else $error("reset released with source active");
   chk_disable_bit: assert property
      (ctrl.logic_reset |-> ctrl.output_disable_bit)
      else $error("output disable not set in reset");
   chk_pin_low: assert property (reset_pin_out == 1'b0)
      else $error("reset pin driven high");
endmodule : srst_controller
`default_nettype wire

//--- test/srst_host_model.sv
// host microcontroller model on the open-drain reset line
`timescale 1ns/1ns
`default_nettype none
module srst_host_model (
   // clock
   input  wire logic clk,
   // bench request and resolved line
   input  wire logic pull_req,
   input  wire logic pin_level,
   // pull-down enable and seen reset
   output var  logic host_oe = 1'b0,
   output var  logic host_in_reset = 1'b0
);
   // changes land just after an edge, never mid-cycle
   always_ff @(posedge clk) begin
      host_oe       <= pull_req;
      host_in_reset <= ~pin_level;
   end
endmodule : srst_host_model
`default_nettype wire

//--- test/tb_smart_reset_controller.sv
// self-checking bench of the smart reset controller
`timescale 1ns/1ns
`default_nettype none
module tb_smart_reset_controller;
   import srst_pkg::*;
   // ---------------------------------------------------------
   // signals
   // ---------------------------------------------------------
   logic        clk, resetn, main_logic_supply_low, power_down;
   logic        main_logic_supply_high, io_supply_low, key_on;
   logic        battery_overvoltage, watchdog_reset_source;
   logic        watchdog_alarm, nolatch_reset_enable, diag_read;
   logic        latch_enable_low, latch_timeout, host_pull;
   logic [7:0]  configuration_register_six;
   logic        reset_pin_out, reset_pin_oe, system_enable;
   logic        watchdog_alarm_output, watchdog_alarm_oe;
   logic        host_oe, host_in_reset;
   wire logic   reset_pin_in;
   srst_flags_t flags;
   srst_ctrl_t  ctrl;
   int          miscompares, tests_run, seed, d;
   // pulled-up wire, low while either party pulls
   assign reset_pin_in = ~(reset_pin_oe | host_oe);
   srst_controller dut (.clk, .resetn, .main_logic_supply_low,
      .main_logic_supply_high, .io_supply_low, .battery_overvoltage,
      .power_down, .key_on, .watchdog_reset_source, .watchdog_alarm,
      .configuration_register_six, .nolatch_reset_enable,
      .latch_enable_low, .latch_timeout, .diag_read, .reset_pin_in,
      .reset_pin_out, .reset_pin_oe, .watchdog_alarm_output,
      .watchdog_alarm_oe, .flags, .ctrl, .system_enable);
   srst_host_model host (.clk, .pull_req(host_pull),
      .pin_level(reset_pin_in), .host_oe, .host_in_reset);
   // ---------------------------------------------------------
   // helpers
   // ---------------------------------------------------------
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task cyc(input int n);
      repeat (n) @(negedge clk);
   endtask : cyc
   // bounded wait, the long filters must not hang the run
   task wait_oe(input logic v, input int max);
      int i;
      i = 0;
      while (reset_pin_oe !== v && i < max) begin
         @(negedge clk);
         i++;
      end
      chk(reset_pin_oe, v);
   endtask : wait_oe
   task rd();
      diag_read = 1'b1;
      cyc(1);
      diag_read = 1'b0;
      cyc(1);
   endtask : rd
   task supply(input logic ok);
      main_logic_supply_low  = ~ok;
      main_logic_supply_high = ok;
   endtask : supply
   task complete_run();
      $display("checks %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : complete_run
   // ---------------------------------------------------------
   // clock and watchdog
   // ---------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // whole run needs about 21000 cycles
   initial begin
      repeat (40000) @(posedge clk);
      miscompares++;
      complete_run();
   end
   // ---------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------
   initial begin
      seed = 28400;
      miscompares = 0;
      tests_run = 0;
      {resetn, main_logic_supply_low, main_logic_supply_high} = '0;
      {io_supply_low, battery_overvoltage, power_down, key_on} = '0;
      {watchdog_reset_source, watchdog_alarm, diag_read} = '0;
      {nolatch_reset_enable, latch_timeout, host_pull} = '0;
      configuration_register_six = 8'h00;
      latch_enable_low = 1'b1;
      cyc(5);
      chk(reset_pin_oe, 1);
      chk(flags, 0);
      chk(ctrl, 5'h1d);
      chk(system_enable, 0);
      chk(reset_pin_out, 0);
      resetn = 1'b1;
      key_on = 1'b1;
      cyc(50);
      chk(reset_pin_oe, 1);
      supply(1);
      wait_oe(0, 5);
      $display("test power-up done");
      power_down = 1'b1;
      cyc(2);
      chk(reset_pin_oe, 1);
      chk(ctrl.supplies_off, 1);
      chk(ctrl.output_disable_bit, 1);
      chk(ctrl.logic_reset, 1);
      power_down = 1'b0;
      wait_oe(0, 5);
      $display("test power-down done");
      // a dip shorter than the filter must pass unseen
      d = {$random(seed)} % 90 + 1;
      supply(0);
      cyc(d);
      supply(1);
      cyc(3);
      chk(reset_pin_oe, 0);
      supply(0);
      cyc(95);
      chk(reset_pin_oe, 0);
      wait_oe(1, 15);
      chk(flags.crank_undervoltage_flag, 1);
      chk(ctrl.lb_reset, 0);
      chk(ctrl.logic_reset, 1);
      supply(1);
      wait_oe(0, 5);
      rd();
      chk(flags.crank_undervoltage_flag, 0);
      configuration_register_six = 8'($random(seed)) | 8'h08;
      supply(0);
      cyc(150);
      chk(reset_pin_oe, 0);
      supply(1);
      configuration_register_six = 8'($random(seed)) & 8'hf7;
      cyc(2);
      $display("test main undervoltage done");
      d = {$random(seed)} % 25 + 1;
      io_supply_low = 1'b1;
      cyc(d);
      io_supply_low = 1'b0;
      cyc(3);
      chk(reset_pin_oe, 0);
      io_supply_low = 1'b1;
      cyc(25);
      chk(reset_pin_oe, 0);
      wait_oe(1, 15);
      io_supply_low = 1'b0;
      wait_oe(0, 5);
      watchdog_reset_source = 1'b1;
      wait_oe(1, 3);
      watchdog_reset_source = 1'b0;
      wait_oe(0, 5);
      $display("test io and watchdog done");
      host_pull = 1'b1;
      cyc(10);
      host_pull = 1'b0;
      cyc(2);
      chk(ctrl.logic_reset, 0);
      host_pull = 1'b1;
      cyc(30);
      chk(ctrl.logic_reset, 1);
      chk(host_in_reset, 1);
      host_pull = 1'b0;
      cyc(10);
      chk(ctrl.logic_reset, 0);
      watchdog_alarm = 1'b1;
      cyc(2);
      chk(watchdog_alarm_oe, 1);
      chk(watchdog_alarm_output, 0);
      watchdog_alarm = 1'b0;
      cyc(2);
      chk(watchdog_alarm_oe, 0);
      $display("test pins done");
      battery_overvoltage = 1'b1;
      cyc(10050);
      chk(ctrl.drivers_off, 1);
      chk(reset_pin_oe, 0);
      chk(flags.battery_overvoltage_flag, 1);
      // no reset here, so the disable bit keeps its cleared value
      chk(ctrl.output_disable_bit, 0);
      battery_overvoltage = 1'b0;
      cyc(3);
      chk(ctrl.drivers_off, 0);
      rd();
      chk(flags.battery_overvoltage_flag, 0);
      $display("test overvoltage done");
      key_on = 1'b0;
      latch_enable_low = 1'b0;
      nolatch_reset_enable = 1'b1;
      cyc(5);
      chk(system_enable, 1);
      key_on = 1'b1;
      wait_oe(1, 3);
      cyc(9980);
      chk(reset_pin_oe, 1);
      wait_oe(0, 40);
      chk(flags.nolatch_pulse_flag, 1);
      key_on = 1'b0;
      cyc(5);
      chk(system_enable, 1);
      latch_timeout = 1'b1;
      cyc(5);
      chk(system_enable, 0);
      $display("test power latch done");
      complete_run();
   end
endmodule : tb_smart_reset_controller
`default_nettype wire
